/* File: ppf_pkg.sv */
// package for the programmable pin function block: modes, limits, register map
// assumes a 50 MHz system clock and a 32-bit avalon-mm register port
package ppf_pkg;

    // ------------------------------------------------------------
    // function selector
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PPF_FN_NONE  = 2'h0,
        PPF_FN_POSAV = 2'h1,
        PPF_FN_RADAR = 2'h2
    } ppf_fn_t;

    // ------------------------------------------------------------
    // timing and limits
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ            = 50_000_000;
    localparam logic [11:0] TIMEOUT_MIN       = 12'h001;
    localparam logic [11:0] TIMEOUT_MAX       = 12'hE10;
    localparam logic [11:0] TIMEOUT_RESET     = 12'h001;
    localparam logic [3:0]  RESET_MODE_A      = 4'h0;
    localparam logic [3:0]  RESET_MODE_B      = 4'h5;
    localparam logic [11:0] RADAR_ARG_ON      = 12'h001;
    // ground speed unit: 0.01 km/hr; 0.8 km/hr .. 322 km/hr
    localparam logic [15:0] SPEED_MIN         = 16'h0050;
    localparam logic [15:0] SPEED_MAX         = 16'h7DC8;
    // f[Hz] = speed[0.01 km/hr] * 94 / 360 ; half period = clk / (2 f)
    // half period cycles = CLK_HZ * 360 / (2 * 94 * speed)
    localparam int unsigned HZ_PER_MPS        = 94;
    localparam logic [31:0] HALF_NUM          =
        32'((64'(CLK_HZ) * 64'd360) / (64'd2 * 64'(HZ_PER_MPS)));

    // ------------------------------------------------------------
    // register map (word offsets in bytes)
    // ------------------------------------------------------------
    localparam logic [3:0]  REG_CONFIG        = 4'h0;
    localparam logic [3:0]  REG_EVENT         = 4'h4;
    localparam logic [3:0]  REG_STATUS        = 4'h8;
    localparam int unsigned CFG_INDEX_LSB     = 28;
    localparam int unsigned CFG_FN_LSB        = 16;
    localparam int unsigned EVT_RESET_MODE_LSB = 0;
    localparam int unsigned EVT_INIT_BIT      = 4;
    localparam int unsigned EVT_CFG_BIT       = 5;
    localparam int unsigned EVT_RESTART_BIT   = 6;

    typedef struct packed {
        logic        pos_valid;
        logic [15:0] speed;
    } ppf_nav_t;

endpackage

/* File: ppf_sync.sv */
// three-stage synchroniser with agreement filter for a pin-level input
// assumes only that clk_sys is running
`timescale 1ns/10ps
module ppf_sync (
    input  wire logic clk_sys,
    input  wire logic reset,
    input  wire logic din,
    output logic      dout
);
    logic st1;
    logic st2;
    logic st3;

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            st1 <= 1'b0;
            st2 <= 1'b0;
            st3 <= 1'b0;
        end else begin
            st1 <= din;
            st2 <= st1;
            st3 <= st2;
        end
    end

    // a change counts only once stages two and three agree
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            dout <= 1'b0;
        end else if (st2 == st3) begin
            dout <= st3;
        end
    end
endmodule

/* File: ppf_divider.sv */
// sequential unsigned divider, one quotient bit per clock
// assumes start is only raised while busy is low
`timescale 1ns/10ps
module ppf_divider (
    input  wire logic        clk_sys,
    input  wire logic        reset,
    input  wire logic        start,
    input  wire logic [31:0] dividend,
    input  wire logic [15:0] divisor,
    output logic             busy,
    output logic             done,
    output logic [31:0]      quotient
);
    logic [31:0] num;
    logic [16:0] rem;
    logic [5:0]  count;
    logic [16:0] trial;
    logic [15:0] dvs;

    // divisor is latched at start: the speed input may move while a division runs
    always_comb begin
        trial = {rem[15:0], num[31]} - {1'b0, dvs};
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            num      <= 32'h0000_0000;
            dvs      <= 16'h0000;
            rem      <= 17'h0_0000;
            count    <= 6'h00;
            busy     <= 1'b0;
            done     <= 1'b0;
            quotient <= 32'h0000_0000;
        end else begin
            done <= 1'b0;
            if (start && !busy) begin
                num   <= dividend;
                dvs   <= divisor;
                rem   <= 17'h0_0000;
                count <= 6'h20;
                busy  <= 1'b1;
            end else if (busy) begin
                if (!trial[16]) begin
                    rem <= trial;
                    num <= {num[30:0], 1'b1};
                end else begin
                    rem <= {rem[15:0], num[31]};
                    num <= {num[30:0], 1'b0};
                end
                count <= count - 6'h01;
                if (count == 6'h01) begin
                    busy     <= 1'b0;
                    done     <= 1'b1;
                    quotient <= !trial[16] ? {num[30:0], 1'b1} : {num[30:0], 1'b0};
                end
            end
        end
    end
endmodule

/* File: ppf_pin.sv */
// programmable pin function: drives one output pin as position-available flag or radar pulse
// assumes nav inputs on clk_sys, a one-cycle second tick, avalon-mm master on clk_sys
//
// What this block does
// - a configuration is accepted only when its pin index is zero.
// - the function is none, position-available or radar pulse, none after reset.
// - the position-available argument is a timeout of 1 to 3600 seconds.
// - the pin is high whenever the selected function does not call for low or pulses.
// - selecting position-available drives the pin low at once if no position exists yet.
// - in position-available mode the pin goes low once positions miss longer than the timeout.
// - in position-available mode init modes 0 or 5 and post-restart configuration drive low.
// - in position-available mode the pin returns high as soon as positions resume.
// - in radar mode with speed from 0.8 to 322 km/hr a 50 percent square wave is output.
// - in radar mode the pulse frequency is 94 Hz per metre per second of ground speed.
// - in radar mode with speed out of range the pin stays high.
//
// Implementation choices: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/10ps
module ppf_pin
    import ppf_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        reset,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    input  wire ppf_nav_t    nav,
    input  wire logic        second_tick,
    input  wire logic        restart_pin,
    output logic             programmable_output_pin
);

    // ------------------------------------------------------------
    // register bus
    // ------------------------------------------------------------
    logic        ack;
    logic        wr_cfg;
    logic        wr_evt;
    logic        cfg_reject;
    ppf_fn_t     function_select;
    logic [11:0] function_argument;
    logic [1:0]  req_fn;
    logic [11:0] req_arg;
    logic [3:0]  req_index;
    logic        req_ok;
    logic        pos_low;
    logic        pos_seen;
    logic [11:0] missing_count;

    // one wait cycle per access; writes land at the edge that sees waitrequest low
    assign avs_waitrequest = (avs_read || avs_write) && !ack;
    assign wr_cfg = avs_write && ack && (avs_address == REG_CONFIG) && (&avs_byteenable);
    assign wr_evt = avs_write && ack && (avs_address == REG_EVENT) && avs_byteenable[0];

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            ack <= 1'b0;
        end else begin
            ack <= (avs_read || avs_write) && !ack;
        end
    end

    always_comb begin
        req_index = avs_writedata[CFG_INDEX_LSB +: 4];
        req_fn    = avs_writedata[CFG_FN_LSB +: 2];
        req_arg   = avs_writedata[11:0];
        req_ok    = 1'b0;
        if (req_index == 4'h0) begin
            case (req_fn)
                PPF_FN_NONE:  req_ok = (req_arg == 12'h000);
                PPF_FN_POSAV: req_ok = (req_arg >= TIMEOUT_MIN) && (req_arg <= TIMEOUT_MAX);
                PPF_FN_RADAR: req_ok = (req_arg == RADAR_ARG_ON);
                default:      req_ok = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            function_select   <= PPF_FN_NONE;
            function_argument <= 12'h000;
            cfg_reject        <= 1'b0;
        end else if (wr_cfg) begin
            cfg_reject <= !req_ok;
            if (req_ok) begin
                function_select   <= ppf_fn_t'(req_fn);
                function_argument <= req_arg;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && !ack) begin
            case (avs_address)
                REG_CONFIG: avs_readdata <= {14'h0000, function_select, 4'h0, function_argument};
                REG_STATUS: avs_readdata <= {12'h000, missing_count, 4'h0,
                                             pos_seen, cfg_reject, pos_low,
                                             programmable_output_pin};
                default:    avs_readdata <= 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // position-available function
    // ------------------------------------------------------------
    logic        restart_sync;
    logic        restart_q;
    logic        after_restart;
    logic        select_posav;
    logic        init_event;
    logic        cfg_event;

    ppf_sync u_restart_sync (
        .clk_sys (clk_sys),
        .reset   (reset),
        .din     (restart_pin),
        .dout    (restart_sync)
    );

    assign select_posav = wr_cfg && req_ok && (req_fn == PPF_FN_POSAV);
    assign init_event = wr_evt && avs_writedata[EVT_INIT_BIT]
                        && ((avs_writedata[EVT_RESET_MODE_LSB +: 4] == RESET_MODE_A)
                         || (avs_writedata[EVT_RESET_MODE_LSB +: 4] == RESET_MODE_B));
    assign cfg_event  = wr_evt && avs_writedata[EVT_CFG_BIT] && after_restart;

    // a restart is held until the first rate and constellation configuration after it
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            restart_q     <= 1'b0;
            after_restart <= 1'b1;
        end else begin
            restart_q <= restart_sync;
            if ((restart_sync && !restart_q)
                || (wr_evt && avs_writedata[EVT_RESTART_BIT])) begin
                after_restart <= 1'b1;
            end else if (cfg_event) begin
                after_restart <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            pos_seen <= 1'b0;
        end else if (nav.pos_valid) begin
            pos_seen <= 1'b1;
        end else if (init_event || cfg_event) begin
            pos_seen <= 1'b0;
        end
    end

    // a position strobe outranks a tick in the same cycle
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            missing_count <= 12'h000;
        end else if (nav.pos_valid || select_posav) begin
            missing_count <= 12'h000;
        end else if (second_tick && (missing_count != 12'hFFF)) begin
            missing_count <= missing_count + 12'h001;
        end
    end

    // the valid strobe wins over every low cause in the same cycle
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            pos_low <= 1'b0;
        end else if (nav.pos_valid) begin
            pos_low <= 1'b0;
        end else if (select_posav && !pos_seen) begin
            pos_low <= 1'b1;
        end else if (init_event || cfg_event) begin
            pos_low <= 1'b1;
        end else if ((function_select == PPF_FN_POSAV) && (missing_count > function_argument)) begin
            pos_low <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // radar pulse function
    // ------------------------------------------------------------
    logic        speed_ok;
    logic        div_start;
    logic        div_busy;
    logic        div_done;
    logic [31:0] div_quot;
    logic [31:0] half_pending;
    logic [31:0] half_period;
    logic [31:0] half_count;
    logic        pulse;
    logic        pulse_run;

    assign speed_ok  = (nav.speed >= SPEED_MIN) && (nav.speed <= SPEED_MAX);
    assign div_start = !div_busy && speed_ok;

    // half period = 50 MHz * 360 / (2 * 94 * speed in 0.01 km/hr)
    ppf_divider u_divider (
        .clk_sys  (clk_sys),
        .reset    (reset),
        .start    (div_start),
        .dividend (HALF_NUM),
        .divisor  (nav.speed),
        .busy     (div_busy),
        .done     (div_done),
        .quotient (div_quot)
    );

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            half_pending <= 32'h0000_0001;
        end else if (div_done) begin
            half_pending <= (div_quot == 32'h0000_0000) ? 32'h0000_0001 : div_quot;
        end
    end

    // the new half period is taken only at the end of a full period, so no runt pulse
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            half_period <= 32'h0000_0001;
            half_count  <= 32'h0000_0000;
            pulse       <= 1'b1;
            pulse_run   <= 1'b0;
        end else if (!(function_select == PPF_FN_RADAR) || !speed_ok) begin
            pulse       <= 1'b1;
            pulse_run   <= 1'b0;
            half_count  <= 32'h0000_0000;
            half_period <= half_pending;
        end else if (!pulse_run) begin
            pulse_run   <= div_done;
            half_period <= div_done ? div_quot : half_period;
            half_count  <= 32'h0000_0000;
        end else if (half_count + 32'h0000_0001 >= half_period) begin
            half_count <= 32'h0000_0000;
            pulse      <= !pulse;
            if (!pulse) begin
                half_period <= half_pending;
            end
        end else begin
            half_count <= half_count + 32'h0000_0001;
        end
    end

    // ------------------------------------------------------------
    // pin drive
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            programmable_output_pin <= 1'b1;
        end else begin
            case (function_select)
                PPF_FN_POSAV: programmable_output_pin <= !pos_low;
                PPF_FN_RADAR: programmable_output_pin <= pulse;
                default:      programmable_output_pin <= 1'b1;
            endcase
        end
    end
endmodule

/* File: ppf_pin_asserts.sv */
// concurrent checks on the programmable pin block, seen from its top ports
// assumes a bench that keeps the avalon rules and never pulses position and tick together
`timescale 1ns/10ps
module ppf_pin_asserts
    import ppf_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        reset,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    input  wire logic [31:0] avs_readdata,
    input  wire logic        avs_waitrequest,
    input  wire ppf_nav_t    nav,
    input  wire logic        second_tick,
    input  wire logic        programmable_output_pin
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    // ----------------------------------------------------------------
    // shadow of the accepted mode; conservative so it never over-claims
    // ----------------------------------------------------------------
    logic [1:0]  mode;
    logic [11:0] arg;
    logic [12:0] miss;
    logic        seen;
    logic        acc;
    logic        cfg_ok;
    logic [1:0]  wfn;
    logic [11:0] warg;
    assign acc  = avs_write && !avs_waitrequest;
    assign wfn  = avs_writedata[17:16];
    assign warg = avs_writedata[11:0];
    assign cfg_ok = acc && avs_address == REG_CONFIG && avs_byteenable == 4'hF
        && avs_writedata[31:28] == 4'h0
        && ((wfn == PPF_FN_NONE && warg == 12'h000)
        || (wfn == PPF_FN_POSAV && warg >= TIMEOUT_MIN && warg <= TIMEOUT_MAX)
        || (wfn == PPF_FN_RADAR && warg == RADAR_ARG_ON));

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            mode <= PPF_FN_NONE;
            arg  <= 12'h000;
        end else if (cfg_ok) begin
            mode <= wfn;
            arg  <= warg;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            miss <= 13'h0000;
        end else if (nav.pos_valid || cfg_ok) begin
            miss <= 13'h0000;
        end else if (second_tick && miss != 13'h1FFF) begin
            miss <= miss + 13'h0001;
        end
    end

    // cleared by reset only: staying set merely makes the select check vacuous
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            seen <= 1'b0;
        end else if (nav.pos_valid) begin
            seen <= 1'b1;
        end
    end

    AST_WAIT_FIRST: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
        else $error("request not held off in its first cycle");
    AST_WAIT_ONE: assert property (
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("request held off for more than one cycle");
    AST_NONE_HIGH: assert property (
        mode == PPF_FN_NONE [*3] |-> programmable_output_pin)
        else $error("pin low with no function selected");
    AST_SELECT_LOW: assert property (
        cfg_ok && wfn == PPF_FN_POSAV && !seen |-> ##[1:3] !programmable_output_pin)
        else $error("pin not low on select without position");
    AST_TIMEOUT_LOW: assert property (
        mode == PPF_FN_POSAV && second_tick && !nav.pos_valid
        && miss == 13'(arg) |-> ##[1:3] !programmable_output_pin)
        else $error("pin not low after timeout");
    AST_INIT_LOW: assert property (
        mode == PPF_FN_POSAV && acc && avs_address == REG_EVENT
        && avs_writedata[4] && (avs_writedata[3:0] == RESET_MODE_A
        || avs_writedata[3:0] == RESET_MODE_B) |-> ##[1:3] !programmable_output_pin)
        else $error("pin not low after init");
    AST_RESUME_HIGH: assert property (
        mode == PPF_FN_POSAV && nav.pos_valid |-> ##[1:3] programmable_output_pin)
        else $error("pin not high after position resumed");
    AST_UNMAPPED_ZERO: assert property (
        avs_read && !avs_waitrequest && avs_address == 4'hC |-> avs_readdata == 32'h0000_0000)
        else $error("unmapped read not zero");
endmodule

bind ppf_pin ppf_pin_asserts u_chk (
    .clk_sys                 (clk_sys),
    .reset                   (reset),
    .avs_address             (avs_address),
    .avs_read                (avs_read),
    .avs_write               (avs_write),
    .avs_writedata           (avs_writedata),
    .avs_byteenable          (avs_byteenable),
    .avs_readdata            (avs_readdata),
    .avs_waitrequest         (avs_waitrequest),
    .nav                     (nav),
    .second_tick             (second_tick),
    .programmable_output_pin (programmable_output_pin)
);

/* File: ppf_pin_reader.sv */
// equipment on the connector: measures high and low run lengths of the pin
// assumes the pin is sampled on clk_sys, so lengths are in clock cycles
`timescale 1ns/10ps
module ppf_pin_reader (
    input  wire logic clk_sys,
    input  wire logic pin,
    output int        high_len,
    output int        low_len,
    output int        edges
);
    int   run  = 0;
    logic prev = 1'b1;
    // lengths are taken at the edge that ends a level, so a stalled pin shows no new figure
    always @(posedge clk_sys) begin
        if (pin !== prev) begin
            if (prev) high_len <= run; else low_len <= run;
            edges <= edges + 1;
            run   <= 1;
        end else begin
            run <= run + 1;
        end
        prev <= pin;
    end
endmodule

/* File: tb.sv */
// self-checking bench for the programmable pin block
// assumes one 50 MHz clock and the one-wait-cycle avalon slave of the design
`timescale 1ns/10ps
module tb;
    import ppf_pkg::*;
    logic clk_sys, reset, avs_read, avs_write, second_tick, restart_pin, pin;
    logic [3:0] avs_address, avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata, rdata;
    logic avs_waitrequest;
    ppf_nav_t nav;
    int n_mismatch = 0, checks_done = 0, cycles = 0, hi, lo, edges, e0;
    logic [15:0] spd [2] = '{SPEED_MAX, 16'h3EE4};
    logic [31:0] bad [6];

`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin n_mismatch++; \
    $display("Error %s expected %0h seen %0h", nm, ex, got); end end

    ppf_pin DUT (.clk_sys(clk_sys), .reset(reset), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .nav(nav), .second_tick(second_tick),
        .restart_pin(restart_pin), .programmable_output_pin(pin));
    ppf_pin_reader u_rd (.clk_sys(clk_sys), .pin(pin), .high_len(hi), .low_len(lo),
        .edges(edges));

    always #10 clk_sys = ~clk_sys;

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // hang guard: the run needs about 64000 cycles
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 90000) begin
            n_mismatch++;
            give_verdict();
        end
    end

    // ----------------------------------------------------------------
    // bus and stimulus tasks
    // ----------------------------------------------------------------
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        // the request stands until an edge samples waitrequest low; that edge completes it
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        rdata = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    function automatic logic [31:0] cfg(logic [3:0] i, logic [1:0] f, logic [11:0] g);
        return {i, 10'h000, f, 4'h0, g};
    endfunction

    task automatic settle(int n);
        repeat (n) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask

    task automatic pulse(input logic tick);
        @(posedge clk_sys);
        if (tick) second_tick <= 1'b1; else nav.pos_valid <= 1'b1;
        @(posedge clk_sys);
        second_tick <= 1'b0;
        nav.pos_valid <= 1'b0;
        settle(4);
    endtask

    initial begin
        clk_sys = 0; reset = 1; avs_read = 0; avs_write = 0; avs_address = 0;
        avs_writedata = 0; avs_byteenable = 4'hF; nav = '0; second_tick = 0; restart_pin = 0;
        bad = '{cfg(1, PPF_FN_POSAV, 60), cfg(0, PPF_FN_NONE, 5), cfg(0, PPF_FN_POSAV, 0),
            cfg(0, PPF_FN_POSAV, 12'hE11), cfg(0, PPF_FN_RADAR, 2), cfg(0, 2'h3, 1)};
        repeat (2) @(posedge clk_sys);
        reset <= 0;
        settle(1);
        `CHK("pin after reset", 1'b1, pin)
        bus(0, REG_STATUS, 0); `CHK("no reject", 1'b0, rdata[2])
        foreach (bad[i]) begin
            bus(1, REG_CONFIG, bad[i]);
            bus(0, REG_STATUS, 0); `CHK("reject", 1'b1, rdata[2])
            `CHK("pin kept", 1'b1, rdata[0])
        end
        bus(1, REG_CONFIG, cfg(0, PPF_FN_POSAV, 2)); settle(3);
        `CHK("select low", 1'b0, pin)
        pulse(0); `CHK("resume", 1'b1, pin)
        for (int t = 1; t <= 3; t++) begin
            pulse(1); `CHK("timeout", t > 2 ? 1'b0 : 1'b1, pin)
        end
        pulse(0); bus(1, REG_EVENT, 32'h0000_0020); settle(3);
        `CHK("first cfg", 1'b0, pin)
        pulse(0); bus(1, REG_EVENT, 32'h0000_0020); settle(3);
        `CHK("second cfg", 1'b1, pin)
        for (int m = 0; m < 6; m++) begin
            pulse(0); bus(1, REG_EVENT, 32'h10 | m); settle(3);
            `CHK("init", (m == 0 || m == 5) ? 1'b0 : 1'b1, pin)
        end
        @(posedge clk_sys);
        restart_pin <= 1'b1; pulse(0); bus(1, REG_EVENT, 32'h0000_0020); settle(3);
        `CHK("restart cfg", 1'b0, pin)
        @(posedge clk_sys);
        nav.speed <= SPEED_MIN - 16'h0001;
        bus(1, REG_CONFIG, cfg(0, PPF_FN_RADAR, 1)); settle(10); e0 = edges;
        settle(3000); `CHK("slow steady", e0, edges)
        foreach (spd[i]) begin
            @(posedge clk_sys);
            nav.speed <= spd[i];
            settle(5 * int'(HALF_NUM / spd[i]) + 200);
            `CHK("high half", int'(HALF_NUM / spd[i]), hi)
            `CHK("low half", int'(HALF_NUM / spd[i]), lo)
        end
        @(posedge clk_sys);
        nav.speed <= SPEED_MAX + 16'h0001; settle(13000); e0 = edges;
        settle(3000); `CHK("fast steady", e0, edges)
        `CHK("fast high", 1'b1, pin)
        bus(1, REG_CONFIG, cfg(0, PPF_FN_NONE, 0)); settle(3);
        `CHK("none high", 1'b1, pin)
        bus(0, 4'hC, 0); `CHK("unmapped", 32'h0000_0000, rdata)
        give_verdict();
    end
endmodule
